// ===== src/tmr3_regs.svh
`ifndef TMR3_REGS_SVH
`define TMR3_REGS_SVH

// control register location on the special function register bus
`define TMR3_CTRL_ADDR 8'h91
`define TMR3_CTRL_PAGE 4'h0
`define TMR3_CTRL_RESET 8'h00
`define TMR3_RDATA_IDLE 8'h00

// control register field positions
`define TMR3_BIT_HIGH_FLAG 7
`define TMR3_BIT_LOW_FLAG 6
`define TMR3_BIT_LOW_IRQ_EN 5
`define TMR3_BIT_CAPTURE_EN 4
`define TMR3_BIT_SPLIT 3
`define TMR3_BIT_RUN 2
`define TMR3_SEL_MSB 1
`define TMR3_SEL_LSB 0

// alternate clock select codes
`define TMR3_SEL_SYSDIV12 2'h0
`define TMR3_SEL_EXTOSC8 2'h1
`define TMR3_SEL_RESERVED 2'h2
`define TMR3_SEL_COMPARATOR 2'h3

// system clock prescaler for the divide-by-12 source
`define TMR3_PRESCALE_LAST 4'hb
`define TMR3_PRESCALE_ZERO 4'h0
`define TMR3_PRESCALE_STEP 4'h1

`endif

// ===== src/tmr3_pkg.sv
`default_nettype none

package tmr3_pkg;

  // source of the external count tick
  typedef enum logic [1:0] {
    SRC_SYSDIV12,
    SRC_EXTOSC8,
    SRC_NONE,
    SRC_COMPARATOR
  } tmr3_clk_src_t;

  // source of the capture trigger
  typedef enum logic [1:0] {
    TRIG_COMPARATOR,
    TRIG_EXTOSC8,
    TRIG_NONE
  } tmr3_trig_src_t;

  // counter arrangement
  typedef enum logic {
    MODE_16BIT,
    MODE_SPLIT8
  } tmr3_mode_t;

endpackage : tmr3_pkg

`default_nettype wire

// ===== src/tmr3_ctrl.sv
// Contract
// - set high flag on high byte wrap
// - high flag requests timer interrupt vector
// - hardware never clears either overflow flag
// - set low flag on every low wrap
// - low enable lets low wrap interrupt
// - capture enable selects capture mode
// - register at 0x91 page 0, resets zero
// - bit3 split, bit2 run, bits1:0 clock
// - split selects two 8-bit counters
// - run gates high; split low always runs
// - decode clock and capture trigger select
// - capture copies count, sets high flag
`include "tmr3_regs.svh"
`default_nettype none

module tmr3_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // special function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // counter datapath strobes, same clock
  input wire logic high_byte_wrap,
  input wire logic low_byte_wrap,
  // interrupt controller enable for this timer
  input wire logic timer_irq_enable,
  // asynchronous trigger sources
  input wire logic comparator_in,
  input wire logic ext_osc_div8_in,
  // interrupt request, then outputs to the counter datapath
  output logic irq,
  output tmr3_pkg::tmr3_mode_t counter_mode,
  output logic high_count_enable,
  output logic low_count_enable,
  output logic capture_mode,
  output tmr3_pkg::tmr3_clk_src_t ext_clock_source,
  output tmr3_pkg::tmr3_trig_src_t capture_trigger,
  output logic ext_clock_tick,
  output logic capture_load
);

  function automatic logic rise(
    input logic prev,
    input logic cur
  );
    rise = cur & ~prev;
  endfunction : rise

  // control register fields
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_overflow_irq_enable;
  logic capture_mode_enable;
  logic split_mode_select;
  logic run_control;
  logic [1:0] alt_clock_select;
  logic next_high_overflow_flag;
  logic next_low_overflow_flag;
  logic next_low_overflow_irq_enable;
  logic next_capture_mode_enable;
  logic next_split_mode_select;
  logic next_run_control;
  logic [1:0] next_alt_clock_select;
  logic [7:0] next_sfr_rdata;

  // trigger synchronisers and edge history
  logic comp_meta;
  logic comp_sync;
  logic comp_prev;
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic next_comp_meta;
  logic next_comp_sync;
  logic next_comp_prev;
  logic next_osc_meta;
  logic next_osc_sync;
  logic next_osc_prev;

  // prescaler and event outputs
  logic [3:0] prescale;
  logic [3:0] next_prescale;
  logic next_ext_clock_tick;
  logic next_capture_load;

  logic sel_hit;
  logic wr_hit;
  logic rd_hit;
  logic comp_edge;
  logic osc_edge;
  logic div12_tick;
  logic capture_event;
  logic [7:0] ctrl_value;

  assign sel_hit = (sfr_addr == `TMR3_CTRL_ADDR) && (sfr_page == `TMR3_CTRL_PAGE);
  assign wr_hit = sfr_wr & sel_hit;
  assign rd_hit = sfr_rd & sel_hit;

  always_comb
  begin
    ctrl_value = `TMR3_CTRL_RESET;
    ctrl_value[`TMR3_BIT_HIGH_FLAG] = high_overflow_flag;
    ctrl_value[`TMR3_BIT_LOW_FLAG] = low_overflow_flag;
    ctrl_value[`TMR3_BIT_LOW_IRQ_EN] = low_overflow_irq_enable;
    ctrl_value[`TMR3_BIT_CAPTURE_EN] = capture_mode_enable;
    ctrl_value[`TMR3_BIT_SPLIT] = split_mode_select;
    ctrl_value[`TMR3_BIT_RUN] = run_control;
    ctrl_value[`TMR3_SEL_MSB:`TMR3_SEL_LSB] = alt_clock_select;
  end

  // only the second synchroniser stage feeds the edge detectors
  assign comp_edge = rise(comp_prev, comp_sync);
  assign osc_edge = rise(osc_prev, osc_sync);
  assign div12_tick = (prescale == `TMR3_PRESCALE_LAST);

  // clock and trigger decode
  always_comb
  begin
    unique case (alt_clock_select)
      `TMR3_SEL_SYSDIV12:
      begin
        ext_clock_source = tmr3_pkg::SRC_SYSDIV12;
        capture_trigger = tmr3_pkg::TRIG_COMPARATOR;
      end
      `TMR3_SEL_EXTOSC8:
      begin
        ext_clock_source = tmr3_pkg::SRC_EXTOSC8;
        capture_trigger = tmr3_pkg::TRIG_EXTOSC8;
      end
      `TMR3_SEL_COMPARATOR:
      begin
        ext_clock_source = tmr3_pkg::SRC_COMPARATOR;
        capture_trigger = tmr3_pkg::TRIG_EXTOSC8;
      end
      // reserved code: no tick and no capture, rather than guess a source
      `TMR3_SEL_RESERVED:
      begin
        ext_clock_source = tmr3_pkg::SRC_NONE;
        capture_trigger = tmr3_pkg::TRIG_NONE;
      end
    endcase
  end

  always_comb
  begin
    unique case (ext_clock_source)
      tmr3_pkg::SRC_SYSDIV12: next_ext_clock_tick = div12_tick;
      tmr3_pkg::SRC_EXTOSC8: next_ext_clock_tick = osc_edge;
      tmr3_pkg::SRC_COMPARATOR: next_ext_clock_tick = comp_edge;
      tmr3_pkg::SRC_NONE: next_ext_clock_tick = 1'b0;
    endcase
  end

  always_comb
  begin
    unique case (capture_trigger)
      tmr3_pkg::TRIG_COMPARATOR: capture_event = comp_edge;
      tmr3_pkg::TRIG_EXTOSC8: capture_event = osc_edge;
      default: capture_event = 1'b0;
    endcase
  end

  // mode outputs
  assign capture_mode = capture_mode_enable;
  assign counter_mode = split_mode_select ? tmr3_pkg::MODE_SPLIT8
                                          : tmr3_pkg::MODE_16BIT;
  assign high_count_enable = run_control;
  assign low_count_enable = split_mode_select | run_control;

  // a low wrap only interrupts when its own enable is set
  assign irq = timer_irq_enable
             & (high_overflow_flag
                | (low_overflow_flag & low_overflow_irq_enable));

  // register next state
  always_comb
  begin
    next_high_overflow_flag = high_overflow_flag;
    next_low_overflow_flag = low_overflow_flag;
    next_low_overflow_irq_enable = low_overflow_irq_enable;
    next_capture_mode_enable = capture_mode_enable;
    next_split_mode_select = split_mode_select;
    next_run_control = run_control;
    next_alt_clock_select = alt_clock_select;
    next_capture_load = capture_mode_enable & capture_event;
    if (wr_hit)
    begin
      // only software writes may clear the flags
      next_high_overflow_flag = sfr_wdata[`TMR3_BIT_HIGH_FLAG];
      next_low_overflow_flag = sfr_wdata[`TMR3_BIT_LOW_FLAG];
      next_low_overflow_irq_enable = sfr_wdata[`TMR3_BIT_LOW_IRQ_EN];
      next_capture_mode_enable = sfr_wdata[`TMR3_BIT_CAPTURE_EN];
      next_split_mode_select = sfr_wdata[`TMR3_BIT_SPLIT];
      next_run_control = sfr_wdata[`TMR3_BIT_RUN];
      next_alt_clock_select = sfr_wdata[`TMR3_SEL_MSB:`TMR3_SEL_LSB];
    end
    // a hardware set in the same cycle as a clearing write wins
    if (high_byte_wrap)
    begin
      next_high_overflow_flag = 1'b1;
    end
    if (next_capture_load)
    begin
      next_high_overflow_flag = 1'b1;
    end
    if (low_byte_wrap)
    begin
      next_low_overflow_flag = 1'b1;
    end
    next_sfr_rdata = rd_hit ? ctrl_value : `TMR3_RDATA_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
      low_overflow_irq_enable <= 1'b0;
      capture_mode_enable <= 1'b0;
      split_mode_select <= 1'b0;
      run_control <= 1'b0;
      alt_clock_select <= `TMR3_SEL_SYSDIV12;
      sfr_rdata <= `TMR3_RDATA_IDLE;
      capture_load <= 1'b0;
    end
    else if (ce)
    begin
      high_overflow_flag <= next_high_overflow_flag;
      low_overflow_flag <= next_low_overflow_flag;
      low_overflow_irq_enable <= next_low_overflow_irq_enable;
      capture_mode_enable <= next_capture_mode_enable;
      split_mode_select <= next_split_mode_select;
      run_control <= next_run_control;
      alt_clock_select <= next_alt_clock_select;
      sfr_rdata <= next_sfr_rdata;
      capture_load <= next_capture_load;
    end
  end

  // synchronisers, edge history and prescaler next state
  always_comb
  begin
    next_comp_meta = comparator_in;
    next_comp_sync = comp_meta;
    next_comp_prev = comp_sync;
    next_osc_meta = ext_osc_div8_in;
    next_osc_sync = osc_meta;
    next_osc_prev = osc_sync;
    if (div12_tick)
    begin
      next_prescale = `TMR3_PRESCALE_ZERO;
    end
    else
    begin
      next_prescale = prescale + `TMR3_PRESCALE_STEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      comp_prev <= 1'b0;
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      prescale <= `TMR3_PRESCALE_ZERO;
      ext_clock_tick <= 1'b0;
    end
    else if (ce)
    begin
      comp_meta <= next_comp_meta;
      comp_sync <= next_comp_sync;
      comp_prev <= next_comp_prev;
      osc_meta <= next_osc_meta;
      osc_sync <= next_osc_sync;
      osc_prev <= next_osc_prev;
      prescale <= next_prescale;
      ext_clock_tick <= next_ext_clock_tick;
    end
  end

endmodule : tmr3_ctrl

`default_nettype wire

// ===== dv/tmr3_ctrl_chk.sv
`include "tmr3_regs.svh"
`default_nettype none

module tmr3_ctrl_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic high_byte_wrap,
  input wire logic low_byte_wrap,
  input wire logic timer_irq_enable,
  input wire logic irq,
  input wire logic capture_mode,
  input wire logic capture_load
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hit;
  assign hit = ce && sfr_addr == `TMR3_CTRL_ADDR && sfr_page == `TMR3_CTRL_PAGE;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_HIGH_SET: assert property (ce && high_byte_wrap ##1 timer_irq_enable |-> irq)
    else $error("no irq after high wrap");
  AST_LOW_SET: assert property (ce && low_byte_wrap ##1 hit && sfr_rd |=> sfr_rdata[6])
    else $error("low flag not read back");
  AST_FLAG_HOLD: assert property (irq && !(hit && sfr_wr) ##1 timer_irq_enable |-> irq)
    else $error("flag dropped without write");
  AST_IRQ_GATE: assert property (!timer_irq_enable |-> !irq)
    else $error("irq while disabled");
  AST_RD_IDLE: assert property (ce && !(hit && sfr_rd) |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  AST_RD_AFTER_WR: assert property (hit && sfr_wr ##1 hit && sfr_rd && !sfr_wr
    |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 2))
    else $error("read back differs");
  AST_CAP_MODE: assert property (hit && sfr_wr |=> capture_mode == $past(sfr_wdata[4]))
    else $error("capture mode wrong");
  AST_CAP_FLAG: assert property (capture_load && timer_irq_enable |-> irq)
    else $error("capture without flag");
  cover property (capture_load);
  cover property (irq ##1 !irq);
  cover property (hit && sfr_wr ##1 hit && sfr_rd);
endmodule : tmr3_ctrl_chk

`default_nettype wire

// ===== dv/tmr3_cpu_model.sv
`default_nettype none

module tmr3_cpu_model (
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic [3:0] sfr_page,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // time at which each strobe was last dropped
  time wr_end = '1;
  time rd_end = '1;
  initial
  begin
    {sfr_addr, sfr_page, sfr_wr, sfr_rd, sfr_wdata} = '0;
  end
  // entered at a falling edge; each strobe covers exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    // a strobe dropped in this time step must see an edge before it rises again
    if (wr_end == $time)
      @(negedge clk);
    sfr_addr = a;
    sfr_page = p;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    // stale data inverted so nothing leans on it after the strobe
    sfr_wdata = ~d;
    wr_end = $time;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [3:0] p, output logic [7:0] d);
    if (rd_end == $time)
      @(negedge clk);
    sfr_addr = a;
    sfr_page = p;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    rd_end = $time;
  endtask : rd
endmodule : tmr3_cpu_model

`default_nettype wire

// ===== dv/tmr3_ctrl_tb_top.sv
`default_nettype none

module tmr3_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, high_byte_wrap = 1'b0, low_byte_wrap = 1'b0;
  logic timer_irq_enable = 1'b1, comparator_in = 1'b0, ext_osc_div8_in = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [3:0] sfr_page;
  logic sfr_wr, sfr_rd, irq, high_count_enable, low_count_enable, capture_mode;
  logic ext_clock_tick, capture_load;
  tmr3_pkg::tmr3_mode_t counter_mode;
  tmr3_pkg::tmr3_clk_src_t ext_clock_source;
  tmr3_pkg::tmr3_trig_src_t capture_trigger;
  logic [7:0] modes [4] = '{8'h0c, 8'h08, 8'h04, 8'h00};
  // capture cases: register value, {comparator, oscillator} drive, {capture, tick}, read back
  logic [7:0] cap_cfg [5] = '{8'h00, 8'h10, 8'h11, 8'h13, 8'h12};
  logic [1:0] cap_drv [5] = '{2'b10, 2'b10, 2'b01, 2'b10, 2'b11};
  logic [1:0] cap_exp [5] = '{2'b00, 2'b10, 2'b11, 2'b01, 2'b00};
  logic [7:0] cap_rd [5] = '{8'h00, 8'h90, 8'h91, 8'h13, 8'h12};
  int failures = 0, n_checks = 0, cyc = 0, n, m;

  tmr3_ctrl i_dut (.*);
  tmr3_cpu_model i_cpu (.*);

  always #4 clk = ~clk;

  task automatic close_out();
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
    logic [7:0] d;
    i_cpu.rd(a, p, d);
    chk("sfr_rdata", d, e);
  endtask : rdc

  // only the chosen strobe is touched, so back-to-back pulses never glitch
  task automatic pulse(input logic hi);
    if (hi)
      high_byte_wrap = 1'b1;
    else
      low_byte_wrap = 1'b1;
    @(negedge clk);
    if (hi)
      high_byte_wrap = 1'b0;
    else
      low_byte_wrap = 1'b0;
  endtask : pulse

  // a hang costs one mismatch and still reaches the verdict
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rdc(8'h91, 4'h0, 8'h00);
    i_cpu.wr(8'h91, 4'h0, 8'hff);
    rdc(8'h91, 4'h0, 8'hff);
    i_cpu.wr(8'h92, 4'h0, 8'h00);
    i_cpu.wr(8'h91, 4'h1, 8'h00);
    rdc(8'h91, 4'h0, 8'hff);
    rdc(8'h92, 4'h0, 8'h00);
    foreach (modes[i])
    begin
      i_cpu.wr(8'h91, 4'h0, modes[i]);
      chk("mode", {counter_mode, high_count_enable, low_count_enable},
          {modes[i][3], modes[i][2], modes[i][3] | modes[i][2]});
    end
    for (int s = 0; s < 4; s++)
    begin
      i_cpu.wr(8'h91, 4'h0, 8'(s));
      chk("source", 8'(ext_clock_source), 8'(s));
      chk("trigger", 8'(capture_trigger), s == 3 ? 8'h01 : 8'(s));
    end
    i_cpu.wr(8'h91, 4'h0, 8'h00);
    n = 0;
    while (ext_clock_tick !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (ext_clock_tick !== 1'b1 && n < 20);
    chk("tick period", 8'(n), 8'd12);
    pulse(1'b0);
    chk("irq", irq, 1'b0);
    rdc(8'h91, 4'h0, 8'h40);
    i_cpu.wr(8'h91, 4'h0, 8'h20);
    chk("irq", irq, 1'b0);
    pulse(1'b0);
    chk("irq", irq, 1'b1);
    repeat (20) @(negedge clk);
    chk("irq", irq, 1'b1);
    timer_irq_enable = 1'b0;
    @(negedge clk);
    chk("irq", irq, 1'b0);
    timer_irq_enable = 1'b1;
    i_cpu.wr(8'h91, 4'h0, 8'h00);
    pulse(1'b1);
    chk("irq", irq, 1'b1);
    pulse(1'b0);
    rdc(8'h91, 4'h0, 8'hc0);
    for (int e = 0; e < 5; e++)
    begin
      i_cpu.wr(8'h91, 4'h0, cap_cfg[e]);
      chk("capture_mode", capture_mode, cap_cfg[e][4]);
      {comparator_in, ext_osc_div8_in} = cap_drv[e];
      n = 0;
      m = 0;
      repeat (8)
      begin
        @(negedge clk);
        n += int'(capture_load === 1'b1);
        m += int'(ext_clock_tick === 1'b1);
      end
      chk("capture", 8'(n), 8'(cap_exp[e][1]));
      // the divide-by-12 source ticks on its own, so only the other three select codes are counted
      if (cap_cfg[e][1:0] != 2'h0)
        chk("tick", 8'(m), 8'(cap_exp[e][0]));
      rdc(8'h91, 4'h0, cap_rd[e]);
      {comparator_in, ext_osc_div8_in} = 2'b00;
      repeat (4) @(negedge clk);
    end
    close_out();
  end
endmodule : tmr3_ctrl_tb_top

bind tmr3_ctrl tmr3_ctrl_chk i_chk (.*);

`default_nettype wire
